/* File: hdl/phy_status_and_ident_regs.sv */
// Basic status low bits and identifier registers of the PHY
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Status bit 6 reads 1: management works with preamble suppressed.
// - Status bit 5 shows auto-negotiation complete; resets to 0.
// - Status bit 4 latches high on far-end or partner fault until read.
// - Status bit 3 always reads 1: auto-negotiation able.
// - Status bit 2 shows valid link at 10 or 100; resets to 0.
// - Link bit latches low; returns high only with good link and a read.
// - Status bit 1 latches high on jabber until read or reset.
// - Jabber bit has meaning only in 10 Mb/s mode.
// - Status bit 0 always reads 1: extended registers present.
// - Two registers carry a 32-bit organization, model, revision ident.
// - Ident high at 88h returns organization bits 3 to 18.
// - Ident low bits 15:10 return organization bits 19 to 24.
// - Ident low bits 9:4 return six-bit model, msb at bit 9.
// - Ident low bits 3:0 return four-bit revision, msb at bit 3.
// - Both ident registers are 16-bit read-only; writes change nothing.
module phy_status_and_ident_regs #(
  // Arbitrary identity values
  parameter logic [23:0] ORG_ID = phy_regs_pkg::ORG_ID_DEFAULT,
  parameter logic [5:0] MODEL = phy_regs_pkg::MODEL_DEFAULT,
  parameter logic [3:0] REV = phy_regs_pkg::REV_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Management access
  input wire phy_regs_pkg::mgmt_req_t req,
  output logic [15:0] rdata_q,
  output logic rvalid_q,
  // Line conditions
  input wire phy_regs_pkg::phy_events_t ev
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic st_rd;
  logic idh_rd;
  logic idl_rd;
  logic [15:0] id_high;
  logic [15:0] id_low;
  logic [15:0] status_word;
  logic [15:0] rdata_d;
  logic an_done_q;
  logic rfault_q;
  logic link_q;
  logic jabber_q;

  assign st_rd = req.rd && (req.addr == phy_regs_pkg::STATUS_OFS);
  assign idh_rd = req.rd && (req.addr == phy_regs_pkg::IDENT_HIGH_OFS);
  assign idl_rd = req.rd && (req.addr == phy_regs_pkg::IDENT_LOW_OFS);

  // ----------------------------------------------------------------
  // Status sources
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      an_done_q <= 1'b0;
    end else begin
      an_done_q <= ev.an_complete;
    end
  end

  // Either fault source latches the bit
  status_latch #(.LATCH_LOW(1'b0)) u_rfault (
    .clk(clk),
    .sys_rst(sys_rst),
    .cond(ev.far_end_fault | ev.lp_remote_fault),
    .rd_clr(st_rd),
    .q(rfault_q)
  );

  // Link drops at once, rises only through a read
  status_latch #(.LATCH_LOW(1'b1)) u_link (
    .clk(clk),
    .sys_rst(sys_rst),
    .cond(ev.link_good),
    .rd_clr(st_rd),
    .q(link_q)
  );

  // Latched in any mode; software ignores it outside 10 Mb/s
  status_latch #(.LATCH_LOW(1'b0)) u_jabber (
    .clk(clk),
    .sys_rst(sys_rst),
    .cond(ev.jabber),
    .rd_clr(st_rd),
    .q(jabber_q)
  );

  // ----------------------------------------------------------------
  // Identifier words
  // ----------------------------------------------------------------
  phy_ident_rom #(
    .ORG_ID(ORG_ID),
    .MODEL(MODEL),
    .REV(REV)
  ) u_ident (
    .id_high(id_high),
    .id_low(id_low)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    status_word = phy_regs_pkg::STATUS_RESET;
    status_word[phy_regs_pkg::BIT_AN_DONE] = an_done_q;
    status_word[phy_regs_pkg::BIT_REMOTE_FAULT] = rfault_q;
    status_word[phy_regs_pkg::BIT_LINK_UP] = link_q;
    status_word[phy_regs_pkg::BIT_JABBER] = jabber_q;
  end

  always_comb begin
    if (st_rd) begin
      rdata_d = status_word;
    end else if (idh_rd) begin
      rdata_d = id_high;
    end else if (idl_rd) begin
      rdata_d = id_low;
    end else begin
      rdata_d = phy_regs_pkg::DATA_ZERO;
    end
  end

  // Writes are not decoded: every register here is read-only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= phy_regs_pkg::DATA_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= req.rd;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Expected identifier fields, rebuilt from the identity parameters
  logic [15:0] chk_org_high;
  logic [5:0] chk_org_low;

  always_comb begin
    chk_org_high = {<<{ORG_ID[phy_regs_pkg::ORG_HIGH_FIRST - 1 +:
      phy_regs_pkg::ORG_HIGH_COUNT]}};
    chk_org_low = {<<{ORG_ID[phy_regs_pkg::ORG_LOW_FIRST - 1 +:
      phy_regs_pkg::ORG_LOW_COUNT]}};
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_preamble_bit;
    st_rd |=> rvalid_q && rdata_q[phy_regs_pkg::BIT_PREAMBLE_SUPP];
  endproperty
  a_preamble_bit: assert property (p_preamble_bit)
    else $error("preamble suppression bit not 1");

  property p_an_done;
    st_rd ##1 !$past(sys_rst, 2) |->
      rdata_q[phy_regs_pkg::BIT_AN_DONE] == $past(ev.an_complete, 2);
  endproperty
  a_an_done: assert property (p_an_done)
    else $error("auto-negotiation complete bit wrong");

  property p_fault_latch;
    (ev.far_end_fault || ev.lp_remote_fault) ##1 st_rd |=>
      rdata_q[phy_regs_pkg::BIT_REMOTE_FAULT];
  endproperty
  a_fault_latch: assert property (p_fault_latch)
    else $error("remote fault not latched");

  property p_fault_clear;
    (st_rd && !ev.far_end_fault && !ev.lp_remote_fault) ##1
      (st_rd && !ev.far_end_fault && !ev.lp_remote_fault) |=>
      !rdata_q[phy_regs_pkg::BIT_REMOTE_FAULT];
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("remote fault not cleared by read");

  property p_fixed_bits;
    st_rd |=> rdata_q[phy_regs_pkg::BIT_AN_ABLE] &&
      rdata_q[phy_regs_pkg::BIT_EXT_CAPABLE];
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("fixed capability bits not 1");

  property p_link_drop;
    !ev.link_good ##1 st_rd |=> !rdata_q[phy_regs_pkg::BIT_LINK_UP];
  endproperty
  a_link_drop: assert property (p_link_drop)
    else $error("link bit high after failure");

  property p_link_return;
    (st_rd && ev.link_good) ##1 (st_rd && ev.link_good) |=>
      rdata_q[phy_regs_pkg::BIT_LINK_UP];
  endproperty
  a_link_return: assert property (p_link_return)
    else $error("link bit not restored by read");

  property p_jabber;
    ev.jabber ##1 (st_rd && !ev.jabber) ##1 (st_rd && !ev.jabber) |->
      rdata_q[phy_regs_pkg::BIT_JABBER] ##1
      !rdata_q[phy_regs_pkg::BIT_JABBER];
  endproperty
  a_jabber: assert property (p_jabber)
    else $error("jabber latch or clear wrong");

  property p_ident_high;
    idh_rd |=> rvalid_q && rdata_q == chk_org_high;
  endproperty
  a_ident_high: assert property (p_ident_high)
    else $error("ident high word wrong");

  property p_ident_low;
    idl_rd |=> rdata_q[15:10] == chk_org_low &&
      rdata_q[9:4] == MODEL && rdata_q[3:0] == REV;
  endproperty
  a_ident_low: assert property (p_ident_low)
    else $error("ident low word wrong");

  property p_ident_ro;
    (req.wr && !req.rd) ##1 idl_rd |=> rdata_q == {chk_org_low, MODEL, REV};
  endproperty
  a_ident_ro: assert property (p_ident_ro)
    else $error("ident changed by write");

  // ----------------------------------------------------------------
  // Answer and reset checks
  // ----------------------------------------------------------------
  property p_reset_clear;
    disable iff (1'b0)
    sys_rst |=> !rvalid_q && rdata_q == phy_regs_pkg::DATA_ZERO &&
      !an_done_q && !rfault_q && !link_q && !jabber_q;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared by reset");

  property p_answer_pulse;
    req.rd |=> rvalid_q;
  endproperty
  a_answer_pulse: assert property (p_answer_pulse)
    else $error("read not answered");

  property p_no_answer;
    !req.rd |=> !rvalid_q && rdata_q == phy_regs_pkg::DATA_ZERO;
  endproperty
  a_no_answer: assert property (p_no_answer)
    else $error("answer without a read");

  property p_unmapped_zero;
    req.rd && !st_rd && !idh_rd && !idl_rd |=>
      rdata_q == phy_regs_pkg::DATA_ZERO;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_status_upper;
    st_rd |=> rdata_q[15:phy_regs_pkg::BIT_PREAMBLE_SUPP + 1] == '0;
  endproperty
  a_status_upper: assert property (p_status_upper)
    else $error("status upper bits not zero");

  property p_ident_high_ro;
    (req.wr && !req.rd) ##1 idh_rd |=> rdata_q == chk_org_high;
  endproperty
  a_ident_high_ro: assert property (p_ident_high_ro)
    else $error("ident high changed by write");

  // ----------------------------------------------------------------
  // Latch checks
  // ----------------------------------------------------------------
  property p_an_set;
    ev.an_complete |=> an_done_q;
  endproperty
  a_an_set: assert property (p_an_set)
    else $error("auto-negotiation done not taken");

  property p_an_clear;
    !ev.an_complete |=> !an_done_q;
  endproperty
  a_an_clear: assert property (p_an_clear)
    else $error("auto-negotiation done not dropped");

  property p_fault_set;
    ev.far_end_fault || ev.lp_remote_fault |=> rfault_q;
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault latch not set");

  property p_fault_hold;
    rfault_q && !st_rd |=> rfault_q;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault latch lost without read");

  property p_fault_quiet;
    !rfault_q && !ev.far_end_fault && !ev.lp_remote_fault |=>
      !rfault_q;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet)
    else $error("fault latch set without event");

  property p_fault_read_clear;
    st_rd && !ev.far_end_fault && !ev.lp_remote_fault |=>
      !rfault_q;
  endproperty
  a_fault_read_clear: assert property (p_fault_read_clear)
    else $error("fault latch not cleared by read");

  property p_link_fail;
    !ev.link_good |=> !link_q;
  endproperty
  a_link_fail: assert property (p_link_fail)
    else $error("link latch kept after failure");

  property p_link_hold_low;
    !link_q && !st_rd |=> !link_q;
  endproperty
  a_link_hold_low: assert property (p_link_hold_low)
    else $error("link latch rose without read");

  property p_link_read_rise;
    st_rd && ev.link_good |=> link_q;
  endproperty
  a_link_read_rise: assert property (p_link_read_rise)
    else $error("link latch not raised by read");

  property p_jabber_set;
    ev.jabber |=> jabber_q;
  endproperty
  a_jabber_set: assert property (p_jabber_set)
    else $error("jabber latch not set");

  property p_jabber_hold;
    jabber_q && !st_rd |=> jabber_q;
  endproperty
  a_jabber_hold: assert property (p_jabber_hold)
    else $error("jabber latch lost without read");

  property p_jabber_read_clear;
    st_rd && !ev.jabber |=> !jabber_q;
  endproperty
  a_jabber_read_clear: assert property (p_jabber_read_clear)
    else $error("jabber latch not cleared by read");

endmodule

`default_nettype wire

/* File: hdl/phy_regs_pkg.sv */
// Register map, field layout and carrier types of the PHY status block
package phy_regs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS = 8'h84;
  localparam logic [7:0] IDENT_HIGH_OFS = 8'h88;
  localparam logic [7:0] IDENT_LOW_OFS = 8'h8C;

  // ----------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------
  localparam int BIT_PREAMBLE_SUPP = 6;
  localparam int BIT_AN_DONE = 5;
  localparam int BIT_REMOTE_FAULT = 4;
  localparam int BIT_AN_ABLE = 3;
  localparam int BIT_LINK_UP = 2;
  localparam int BIT_JABBER = 1;
  localparam int BIT_EXT_CAPABLE = 0;

  // ----------------------------------------------------------------
  // Reset and idle values
  // ----------------------------------------------------------------
  localparam logic [15:0] STATUS_RESET = 16'h0049;
  localparam logic [15:0] DATA_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Identifier field layout
  // ----------------------------------------------------------------
  localparam int ORG_HIGH_FIRST = 3;
  localparam int ORG_HIGH_COUNT = 16;
  localparam int ORG_LOW_FIRST = 19;
  localparam int ORG_LOW_COUNT = 6;
  localparam int ORG_LOW_TOP = 15;
  localparam int MODEL_MSB = 9;
  localparam int MODEL_LSB = 4;
  localparam int REV_MSB = 3;
  localparam int REV_LSB = 0;

  // Arbitrary identity values, not those of any real part
  localparam logic [23:0] ORG_ID_DEFAULT = 24'h00A5A4;
  localparam logic [5:0] MODEL_DEFAULT = 6'h15;
  localparam logic [3:0] REV_DEFAULT = 4'h3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic an_complete;
    logic far_end_fault;
    logic lp_remote_fault;
    logic link_good;
    logic jabber;
  } phy_events_t;

endpackage

/* File: hdl/status_latch.sv */
// One latching status bit, latch-high or latch-low, cleared by a read
`timescale 1ns/10ps
`default_nettype none

module status_latch #(
  parameter logic LATCH_LOW = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Condition and read clear
  input wire logic cond,
  input wire logic rd_clr,
  // Latched state
  output logic q
);

  // ----------------------------------------------------------------
  // Latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= 1'b0;
    end else if (LATCH_LOW) begin
      // Failure wins over the read
      q <= rd_clr ? cond : (q & cond);
    end else begin
      // Set wins over the read clear
      q <= cond | (q & ~rd_clr);
    end
  end

endmodule

`default_nettype wire

/* File: hdl/phy_ident_rom.sv */
// Fixed identifier words assembled from identity parameters
`timescale 1ns/10ps
`default_nettype none

module phy_ident_rom #(
  parameter logic [23:0] ORG_ID = phy_regs_pkg::ORG_ID_DEFAULT,
  parameter logic [5:0] MODEL = phy_regs_pkg::MODEL_DEFAULT,
  parameter logic [3:0] REV = phy_regs_pkg::REV_DEFAULT
) (
  // Identifier words
  output wire logic [15:0] id_high,
  output wire logic [15:0] id_low
);

  // ----------------------------------------------------------------
  // Organization bits, first bit at the top of each field
  // ----------------------------------------------------------------
  genvar i;
  for (i = 0; i < phy_regs_pkg::ORG_HIGH_COUNT; i++) begin : g_high
    assign id_high[15 - i] = ORG_ID[phy_regs_pkg::ORG_HIGH_FIRST - 1 + i];
  end
  for (i = 0; i < phy_regs_pkg::ORG_LOW_COUNT; i++) begin : g_low
    assign id_low[phy_regs_pkg::ORG_LOW_TOP - i] =
      ORG_ID[phy_regs_pkg::ORG_LOW_FIRST - 1 + i];
  end

  // ----------------------------------------------------------------
  // Model and revision
  // ----------------------------------------------------------------
  assign id_low[phy_regs_pkg::MODEL_MSB:phy_regs_pkg::MODEL_LSB] = MODEL;
  assign id_low[phy_regs_pkg::REV_MSB:phy_regs_pkg::REV_LSB] = REV;

endmodule

`default_nettype wire

/* File: dv/mgmt_host.sv */
// Management host model issuing register reads and writes
`timescale 1ns/10ps
`default_nettype none

module mgmt_host (
  // Clock
  input wire logic clk,
  // Request
  output var phy_regs_pkg::mgmt_req_t req
);
  initial req = '0;

  // ----------------------------------------------------------------
  // One request, held across one rising edge
  // ----------------------------------------------------------------
  task automatic op(input logic r, input logic w, input logic [7:0] a,
                    input logic [15:0] d);
    req.rd = r;
    req.wr = w;
    req.addr = a;
    req.wdata = d;
    @(posedge clk);
    #1;
  endtask
endmodule

`default_nettype wire

/* File: dv/test_phy_status_and_ident_regs.sv */
// Self-checking bench of the PHY status and identifier registers
`timescale 1ns/10ps
`default_nettype none

module test_phy_status_and_ident_regs;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic run = 1'b0;
  phy_regs_pkg::mgmt_req_t req;
  phy_regs_pkg::phy_events_t ev = '0;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic [31:0] seed = 32'h0000003A;
  logic an_q, flt_q, lnk_q, jab_q, exp_rv;
  logic [15:0] exp_rd;
  int fail_count = 0;
  int n_compared = 0;
  // Entries: events, kind (1 read, 2 write, 0 idle), address
  logic [19:0] seq [$] = {20'h00000, 20'h00184, 20'h08000, 20'h00184,
    20'h00184, 20'h04184, 20'h00184, 20'h00184, 20'h01000, 20'h00184,
    20'h01184, 20'h00184, 20'h02000, 20'h02184, 20'h02184, 20'h00000,
    20'h02184, 20'h02184, 20'h00184, 20'h00184, 20'h10000, 20'h10184,
    20'h00184, 20'h00184, 20'h00288, 20'h0028C, 20'h00284, 20'h00188,
    20'h0018C, 20'h00184, 20'h00100, 20'h00190, 20'h00000};
  wire stat_rd = req.rd & (req.addr == 8'h84);

  always #5 clk = ~clk;

  mgmt_host u_mgmt_host (
    .clk(clk),
    .req(req)
  );

  phy_status_and_ident_regs u_phy_status_and_ident_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .req(req),
    .rdata_q(rdata_q),
    .rvalid_q(rvalid_q),
    .ev(ev)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  function automatic logic [15:0] exp_word(input logic [7:0] a);
    logic [23:0] o;
    logic [15:0] w;
    o = phy_regs_pkg::ORG_ID_DEFAULT;
    w = 16'h0000;
    if (a == 8'h84)
      w = {9'h000, 1'b1, an_q, flt_q, 1'b1, lnk_q, jab_q, 1'b1};
    if (a == 8'h88)
      for (int i = 0; i < 16; i++)
        w[15-i] = o[2+i];
    if (a == 8'h8C) begin
      for (int i = 0; i < 6; i++)
        w[15-i] = o[18+i];
      w[9:0] = {phy_regs_pkg::MODEL_DEFAULT, phy_regs_pkg::REV_DEFAULT};
    end
    return w;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("TB: %0d compared, %0d failed", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Reference state and comparison
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      {an_q, flt_q, lnk_q, jab_q, exp_rv} <= '0;
      exp_rd <= 16'h0000;
    end else begin
      an_q <= ev.an_complete;
      flt_q <= ev.far_end_fault | ev.lp_remote_fault | (flt_q & !stat_rd);
      jab_q <= ev.jabber | (jab_q & !stat_rd);
      lnk_q <= ev.link_good & (lnk_q | stat_rd);
      exp_rv <= req.rd;
      exp_rd <= req.rd ? exp_word(req.addr) : 16'h0000;
    end
  end

  always @(negedge clk) begin
    if (run) begin
      check({15'h0000, rvalid_q}, {15'h0000, exp_rv});
      check(rdata_q, exp_rd);
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] r;
    logic [7:0] a;
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    run = 1'b1;
    foreach (seq[i]) begin
      ev = seq[i][16:12];
      a = (seq[i][9:8] != 2'd0) ? seq[i][7:0] : ~req.addr;
      u_mgmt_host.op(seq[i][8], seq[i][9], a, xs());
    end
    $display("TB: directed corner test done");
    // Set every latch, then reset in mid-run with all events still high
    ev = '1;
    u_mgmt_host.op(1'b1, 1'b0, 8'h84, 16'h0000);
    sys_rst = 1'b1;
    repeat (2) u_mgmt_host.op(1'b1, 1'b0, 8'h84, 16'h0000);
    ev = '0;
    sys_rst = 1'b0;
    repeat (2) u_mgmt_host.op(1'b1, 1'b0, 8'h84, 16'h0000);
    $display("TB: mid-run reset test done");
    repeat (600) begin
      r = xs();
      ev = r[4:0] & {1'b1, r[6], r[7], 1'b1, r[8]};
      a = r[11] ? 8'h84 : (r[10] ? {4'h8, r[15:14], 2'b00} : r[15:8]);
      u_mgmt_host.op(r[12], r[13] & !r[12], a, xs());
    end
    $display("TB: random traffic test done");
    final_report();
  end

  initial begin
    #20000;
    fail_count++;
    $display("Error at %0t: run did not finish in time", $time);
    final_report();
  end
endmodule

`default_nettype wire
